/* design/pwd_defines.svh */
`ifndef PWD_DEFINES_SVH
`define PWD_DEFINES_SVH

// Register byte offsets
`define PWD_OFF_CTRL     8'h00
`define PWD_OFF_PERIOD   8'h04
`define PWD_OFF_DUTY_WR  8'h08
`define PWD_OFF_DUTY_ACT 8'h0c
`define PWD_OFF_TIMER    8'h10
`define PWD_OFF_TCON     8'h14
`define PWD_OFF_STATUS   8'h18

// Control register fields
`define PWD_CTRL_MODE_HI 3
`define PWD_CTRL_MODE_LO 0
`define PWD_CTRL_LSB_HI  5
`define PWD_CTRL_LSB_LO  4
`define PWD_MODE_PWM     4'hc

// Timer control fields
`define PWD_TCON_PRE_HI  1
`define PWD_TCON_PRE_LO  0
`define PWD_TCON_ON_BIT  2

// Reset values
`define PWD_RST_CTRL     8'h00
`define PWD_RST_PERIOD   8'hff
`define PWD_RST_DUTY     8'h00
`define PWD_RST_TCON     8'h00
`define PWD_RST_TIMER    8'h00

// Timing: oscillator period and quarter-cycle divide
`define PWD_TOSC_NS      20
`define PWD_Q_PER_INSN   4
`define PWD_SUB_MAX_1    6'h03
`define PWD_SUB_MAX_4    6'h0f
`define PWD_SUB_MAX_16   6'h3f

`endif

/* design/pwd_pkg.sv */
package pwd_pkg;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } pwd_ahb_req_type;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } pwd_ahb_rsp_type;

  typedef enum logic [1:0] {
    PWD_PRE_1,
    PWD_PRE_4,
    PWD_PRE_16,
    PWD_PRE_16B
  } pwd_prescale_type;

  typedef struct packed {
    logic [5:0] cnt;
  } pwd_tick_state_type;

  typedef struct packed {
    pwd_ahb_rsp_type rsp;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [7:0]      ctrl;
    logic [7:0]      period;
    logic [7:0]      duty_wr;
    logic [7:0]      duty_act;
    logic [1:0]      duty_lo2;
    logic [7:0]      tcon;
    logic [7:0]      timer;
    logic            pin;
    logic            match;
  } pwd_state_type;

endpackage : pwd_pkg

/* design/pwd_tick.sv */
`timescale 1ns/100ps
`include "pwd_defines.svh"

module pwd_tick
  import pwd_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             run,
  input  wire pwd_prescale_type presc,
  output logic                  tick,
  output logic [1:0]            sub
);

  pwd_tick_state_type s_q;
  pwd_tick_state_type s_d;
  logic [5:0]         max_cnt;

  // Quarter-cycle clock times prescale factor
  always_comb begin
    case (presc)
      PWD_PRE_1: begin
        max_cnt = `PWD_SUB_MAX_1;
      end
      PWD_PRE_4: begin
        max_cnt = `PWD_SUB_MAX_4;
      end
      default: begin
        max_cnt = `PWD_SUB_MAX_16;
      end
    endcase
    tick = run && (s_q.cnt == max_cnt);
    s_d  = s_q;
    if (!run || tick) begin
      s_d.cnt = 6'h00;
    end else begin
      s_d.cnt = s_q.cnt + 6'h01;
    end
    // Fine bits of the coming cycle
    case (presc)
      PWD_PRE_1: begin
        sub = s_d.cnt[1:0];
      end
      PWD_PRE_4: begin
        sub = s_d.cnt[3:2];
      end
      default: begin
        sub = s_d.cnt[5:4];
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : pwd_tick

/* design/pwd_top.sv */
// Notes on behaviour
// - The block drives one pulse output with a duty resolution of ten bits.
// - Writing zero to the whole control register forces the output low.
// - Period is (period register + 1) times 4 clocks times the prescale.
// - When the timer equals the period register it clears on next increment.
// - On that increment the written duty moves into the active buffer.
// - On that increment the output goes high unless the duty is zero.
// - The postscaler field has no effect on period or frequency.
// - Duty is the write register as upper eight bits and control bits 5:4.
// - High time is the duty value times the clock times the prescale.
// - Duty writes are taken any time but act only after a period match.
// - In pulse mode the active duty buffer is read-only.
// - Active buffer plus a hidden two-bit latch double-buffer the duty.
// - Output clears when the active duty equals timer with two fine bits.
// - A duty beyond the period never clears the output in that period.
`timescale 1ns/100ps
`include "pwd_defines.svh"

module pwd_top
  import pwd_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            srst,
  input  wire pwd_ahb_req_type ahb_req,
  output pwd_ahb_rsp_type      ahb_rsp,
  output logic                 pulse_output_pin,
  output logic                 period_match
);

  pwd_state_type    s_q;
  pwd_state_type    s_d;
  logic             tick;
  logic [1:0]       sub;
  logic             run;
  pwd_prescale_type presc;
  logic             addr_phase;
  logic             at_period;
  logic             fine_hit;
  logic [9:0]       duty_next;
  logic [31:0]      rd_word;

  function automatic logic pwd_is_pwm(input logic [7:0] ctrl);
    pwd_is_pwm =
      (ctrl[`PWD_CTRL_MODE_HI:`PWD_CTRL_MODE_LO] == `PWD_MODE_PWM);
  endfunction : pwd_is_pwm

  function automatic logic [31:0] pwd_read(input pwd_state_type s,
                                           input logic [7:0]   addr);
    case (addr)
      `PWD_OFF_CTRL:     pwd_read = {24'h000000, s.ctrl};
      `PWD_OFF_PERIOD:   pwd_read = {24'h000000, s.period};
      `PWD_OFF_DUTY_WR:  pwd_read = {24'h000000, s.duty_wr};
      `PWD_OFF_DUTY_ACT: pwd_read = {24'h000000, s.duty_act};
      `PWD_OFF_TIMER:    pwd_read = {24'h000000, s.timer};
      `PWD_OFF_TCON:     pwd_read = {24'h000000, s.tcon};
      `PWD_OFF_STATUS:   pwd_read = {30'h0, s.match, s.pin};
      default:           pwd_read = 32'h00000000;
    endcase
  endfunction : pwd_read

  assign run   = s_q.tcon[`PWD_TCON_ON_BIT];
  // Postscaler bits of tcon are stored only
  assign presc = pwd_prescale_type'(
                   s_q.tcon[`PWD_TCON_PRE_HI:`PWD_TCON_PRE_LO]);

  pwd_tick pwd_tick_inst (
    .clk   (clk),
    .srst  (srst),
    .run   (run),
    .presc (presc),
    .tick  (tick),
    .sub   (sub)
  );

  assign addr_phase = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  assign at_period  = tick && (s_q.timer == s_q.period);
  assign duty_next  = {s_q.duty_wr,
                       s_q.ctrl[`PWD_CTRL_LSB_HI:`PWD_CTRL_LSB_LO]};

  always_comb begin
    s_d       = s_q;
    s_d.match = 1'b0;
    rd_word   = 32'h00000000;

    // Data phase of a write
    if (s_q.wr_pend) begin
      s_d.wr_pend = 1'b0;
      case (s_q.wr_addr)
        `PWD_OFF_CTRL: begin
          s_d.ctrl = ahb_req.hwdata[7:0];
        end
        `PWD_OFF_PERIOD: begin
          s_d.period = ahb_req.hwdata[7:0];
        end
        `PWD_OFF_DUTY_WR: begin
          s_d.duty_wr = ahb_req.hwdata[7:0];
        end
        `PWD_OFF_DUTY_ACT: begin
          if (!pwd_is_pwm(s_q.ctrl)) begin
            s_d.duty_act = ahb_req.hwdata[7:0];
          end
        end
        `PWD_OFF_TIMER: begin
          s_d.timer = ahb_req.hwdata[7:0];
        end
        `PWD_OFF_TCON: begin
          s_d.tcon = ahb_req.hwdata[7:0];
        end
        default: begin
          s_d.wr_pend = 1'b0;
        end
      endcase
    end

    // Period timer and modulator
    if (tick) begin
      if (at_period) begin
        s_d.timer = 8'h00;
        s_d.match = 1'b1;
      end else begin
        s_d.timer = s_q.timer + 8'h01;
      end
    end

    // Next position, so the registered pin falls on time
    // Duty beyond the period never matches
    fine_hit = ({s_q.duty_act, s_q.duty_lo2} ==
                {s_d.timer, sub});
    if (pwd_is_pwm(s_q.ctrl)) begin
      if (at_period) begin
        s_d.duty_act = duty_next[9:2];
        s_d.duty_lo2 = duty_next[1:0];
        s_d.pin      = (duty_next != 10'h000);
      end else if (fine_hit) begin
        s_d.pin = 1'b0;
      end
    end else begin
      s_d.pin = 1'b0;
    end

    // Zeroing the control register drops the output latch
    if (s_q.wr_pend && (s_q.wr_addr == `PWD_OFF_CTRL) &&
        (ahb_req.hwdata[7:0] == 8'h00)) begin
      s_d.pin = 1'b0;
    end

    // Address phase: latch write target or read data
    s_d.rsp.hreadyout = 1'b1;
    s_d.rsp.hresp     = 1'b0;
    if (addr_phase) begin
      if (ahb_req.hwrite) begin
        s_d.wr_pend = (ahb_req.haddr[31:8] == 24'h000000);
        s_d.wr_addr = ahb_req.haddr[7:0];
      end else begin
        if (ahb_req.haddr[31:8] == 24'h000000) begin
          rd_word = pwd_read(s_d, ahb_req.haddr[7:0]);
        end
        s_d.rsp.hrdata = rd_word;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q               <= '0;
      s_q.rsp.hreadyout <= 1'b1;
      s_q.ctrl          <= `PWD_RST_CTRL;
      s_q.period        <= `PWD_RST_PERIOD;
      s_q.duty_wr       <= `PWD_RST_DUTY;
      s_q.duty_act      <= `PWD_RST_DUTY;
      s_q.tcon          <= `PWD_RST_TCON;
      s_q.timer         <= `PWD_RST_TIMER;
    end else begin
      s_q <= s_d;
    end
  end

  assign ahb_rsp          = s_q.rsp;
  assign pulse_output_pin = s_q.pin;
  assign period_match     = s_q.match;

endmodule : pwd_top

/* verif/pwd_top_checker.sv */
`timescale 1ns/100ps
module pwd_top_checker
  import pwd_pkg::*;
(
  input wire logic            clk,
  input wire logic            srst,
  input wire pwd_ahb_req_type ahb_req,
  input wire pwd_ahb_rsp_type ahb_rsp,
  input wire logic            pulse_output_pin,
  input wire logic            period_match
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire acc = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
  wire rd_ph = acc && !ahb_req.hwrite;
  wire ctl_wr = acc && ahb_req.hwrite && ahb_req.haddr == 32'h0;
  a_bus_ready: assert property (ahb_rsp.hreadyout)
    else $error("bus stalled");
  a_resp_okay: assert property (!ahb_rsp.hresp)
    else $error("bus error response");
  a_match_spacing: assert property (
    period_match |=> !period_match [*3]) else $error("period too short");
  a_rise_at_wrap: assert property (
    $rose(pulse_output_pin) |-> period_match) else $error("rise off wrap");
  a_clear_low: assert property (
    ctl_wr ##1 ahb_req.hwdata[7:0] == 8'h00 |=> !pulse_output_pin)
    else $error("pin high after control clear");
  a_unmapped_zero: assert property (
    rd_ph && ahb_req.haddr == 32'h1c |=> ahb_rsp.hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (rd_ph |=> ahb_rsp.hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_reset_quiet: assert property ($past(srst) |->
    !period_match && !pulse_output_pin && ahb_rsp.hrdata == 32'h0)
    else $error("outputs active after reset");
  cover property (period_match);
  cover property ($fell(pulse_output_pin));
  cover property (ctl_wr);
endmodule : pwd_top_checker

bind pwd_top pwd_top_checker pwd_top_checker_inst (.clk(clk), .srst(srst),
  .ahb_req(ahb_req), .ahb_rsp(ahb_rsp),
  .pulse_output_pin(pulse_output_pin), .period_match(period_match));

/* verif/pwd_load.sv */
`timescale 1ns/100ps
module pwd_load
(
  input  wire logic clk,
  input  wire logic pin,
  output int        per_len
);
  int   cnt  = 0;
  logic last = 1'b0;
  // Cycles between rising edges of the load voltage
  always @(posedge clk) begin
    if (pin && !last) begin
      per_len <= cnt;
      cnt     <= 1;
    end else begin
      cnt <= cnt + 1;
    end
    last <= pin;
  end
endmodule : pwd_load

/* verif/pwd_duty_period_generator_test.sv */
`timescale 1ns/100ps
`include "pwd_defines.svh"
module pwm_duty_period_generator_test
  import pwd_pkg::*;
;
  logic            clk = 1'b0, srst = 1'b1, pin, match;
  pwd_ahb_req_type bus = '0, req;
  pwd_ahb_rsp_type rsp;
  int              err_total = 0, checks = 0, cyc = 0, per_len;
  logic [31:0]     seed = 32'h7b1c, rd;
  logic [7:0]      offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
                                8'h18, 8'h1c};

  pwd_top pwd_top_inst (.clk(clk), .srst(srst), .ahb_req(req),
    .ahb_rsp(rsp), .pulse_output_pin(pin), .period_match(match));
  pwd_load pwd_load_inst (.clk(clk), .pin(pin), .per_len(per_len));

  always_comb begin
    req = bus;
    req.hready = rsp.hreadyout;
  end
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      print_verdict;
    end
  end

  task print_verdict;
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task chk(input logic [31:0] v, input logic [31:0] e);
    checks++;
    if (v !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, v, e);
    end
  endtask : chk

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    bus <= '{1'b1, {24'h0, a}, 2'h2, w, 3'h2, 32'h0, 1'b0};
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    bus.htrans <= 2'h0;
    bus.hwdata <= wd;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    rd = rsp.hrdata;
  endtask : xfer

  function int pre_of(input int pc);
    return pc == 0 ? 1 : pc == 1 ? 4 : 16;
  endfunction : pre_of

  function int exp_hi(input int d, input int pc, input int p);
    return (d >= (p + 1) * 4 ? (p + 1) * 4 : d) * pre_of(pc);
  endfunction : exp_hi

  task wm;
    int k;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (match !== 1'b1 && k < 20000);
    if (k >= 20000) err_total++;
  endtask : wm

  task meas(input int per, input int ehi);
    int hc;
    wm;
    hc = 0;
    repeat (per) begin
      hc += (pin === 1'b1);
      @(negedge clk);
    end
    chk(hc, ehi);
    if (ehi > 0 && ehi < per) chk(per_len, per);
  endtask : meas

  task cfg(input int p, input int d, input int pc);
    xfer(1'b1, `PWD_OFF_CTRL, 32'h0);
    xfer(1'b0, `PWD_OFF_STATUS, 32'h0);
    chk(rd & 32'h1, 32'h0);
    xfer(1'b1, `PWD_OFF_TCON, 32'h0);
    xfer(1'b1, `PWD_OFF_TIMER, 32'h0);
    xfer(1'b1, `PWD_OFF_PERIOD, p);
    xfer(1'b1, `PWD_OFF_DUTY_WR, (d >> 2) & 255);
    xfer(1'b1, `PWD_OFF_CTRL, {d[1:0], `PWD_MODE_PWM});
    xfer(1'b1, `PWD_OFF_TCON, 32'({5'($random(seed)), 1'b1, 2'(pc)}));
    wm;
    wm;
  endtask : cfg

  initial begin
    int p, d, pc;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    foreach (offs[i]) begin
      xfer(1'b0, offs[i], 32'h0);
      chk(rd, i == 1 ? 32'hff : 32'h0);
    end
    xfer(1'b1, 8'h1c, 32'hff);
    xfer(1'b0, 8'h1c, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      p = $random(seed) & 7;
      pc = i < 4 ? i : $random(seed) & 3;
      d = ($random(seed) & 32'h3ff) % ((p + 1) * 4);
      if (i < 2) d = i == 0 ? 0 : 32'h3ff;
      cfg(p, d, pc);
      meas((p + 1) * 4 * pre_of(pc), exp_hi(d, pc, p));
      xfer(1'b0, `PWD_OFF_DUTY_ACT, 32'h0);
      chk(rd, (d >> 2) & 255);
      xfer(1'b1, `PWD_OFF_DUTY_ACT, 32'h5a);
      xfer(1'b0, `PWD_OFF_DUTY_ACT, 32'h0);
      chk(rd, (d >> 2) & 255);
    end
    cfg(7, 24, 0);
    meas(32, 24);
    wm;
    xfer(1'b1, `PWD_OFF_DUTY_WR, 32'h1);
    xfer(1'b1, `PWD_OFF_CTRL, {28'h0, `PWD_MODE_PWM});
    @(negedge clk);
    chk(pin, 32'h1);
    meas(32, 4);
    print_verdict;
  end
endmodule : pwm_duty_period_generator_test
